/* File: design/clkmgr_params.svh */
`ifndef CLKMGR_PARAMS_SVH
`define CLKMGR_PARAMS_SVH

// register byte offsets
`define OFF_MAIN_SRC 12'h000
`define OFF_CPU_DIV 12'h004
`define OFF_HSB_MIRROR 12'h008
`define OFF_PBA_DIV 12'h00c
`define OFF_PBB_DIV 12'h010
`define OFF_CPU_GATES 12'h020
`define OFF_HSB_GATES 12'h024
`define OFF_PBA_GATES 12'h028
`define OFF_PBB_GATES 12'h02c
`define OFF_PBA_DIVGATES 12'h040
`define OFF_CFD_CTRL 12'h054
`define OFF_UNLOCK 12'h058
`define OFF_IRQ_EN_SET 12'h0c0
`define OFF_IRQ_EN_CLR 12'h0c4
`define OFF_IRQ_EN_STATE 12'h0c8
`define OFF_IRQ_PEND 12'h0cc
`define OFF_IRQ_PEND_CLR 12'h0d0
`define OFF_STATUS 12'h0d4
`define OFF_PERIPH_PWR 12'h160
`define OFF_RST_SRC 12'h180
`define OFF_WAKE_SRC 12'h184
`define OFF_ASYNC_WAKE 12'h188
`define OFF_CONFIG 12'h3f8
`define OFF_REVISION 12'h3fc

// reset values
`define RST_CPU_GATES 32'h00010001
`define RST_HSB_GATES 32'h0000007f
`define RST_PBA_GATES 32'h00ffffff
`define RST_PBB_GATES 32'h0000000f
`define RST_PBA_DIVGATES 32'h0000007f
`define RST_PERIPH_PWR 32'h000001fa
`define VAL_CONFIG 32'h00000043
// revision value is arbitrary
`define VAL_REVISION 32'h00000100

// field positions
`define BIT_DIV 7
`define BIT_FAILURE_DETECT_ENABLE 0
`define BIT_SFV 31
`define BIT_ST_CFD 0
`define BIT_ST_CLOCK_READY_FLAG 5
`define BIT_ST_AE 6
`define KEY_LSB 24
`define UNLOCK_KEY 8'haa

// main clock source codes
`define SRC_SYSTEM_RC_OSC 3'h0
`define SRC_CRYSTAL_OSC_ZERO 3'h1
`define SRC_FLL 3'h2
`define SRC_RC120 3'h3

`endif

/* File: design/clkmgr_pkg.sv */
package clkmgr_pkg;
    // divider switch sequencer
    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_WAIT = 2'b01,
        SW_SETTLE = 2'b10
    } switch_state_t;
endpackage

/* File: design/clock_manager.sv */
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "clkmgr_params.svh"

// Functional notes
// - low external reset pin forces system reset
// - no main edge per reference period: failure
// - failure switches to RC, raises failure interrupt
// - enable bit turns detector on
// - no monitoring on RC, unavailable, deep sleep
// - failure rewrites source field to zero
// - locked write without unlock raises access error
// - clock-ready rises when new dividers apply
// - pending bit sets on rise, clears by write
// - enable set/clear by writing ones only
// - masked pending bits ORed into one request
// - source codes: rc, crystal_osc_zero, fll, fast rc
// - divide bit: main clock over 2^(sel+1)
// - divider write clears clock-ready
// - high-speed bus register mirrors processor divider
// - peripheral bus divided likewise by its bit
module clock_manager (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_reset_n,
    input wire logic main_clk_sample,
    input wire logic rc_ref_sample,
    input wire logic main_clk_avail,
    input wire logic deep_sleep,
    output logic sys_reset_n,
    output logic [2:0] main_src_sel,
    output logic cpu_clk_en,
    output logic hsb_clk_en,
    output logic pba_clk_en,
    output logic pbb_clk_en,
    output logic [31:0] cpu_gates,
    output logic [31:0] hsb_gates,
    output logic [31:0] pba_gates,
    output logic [31:0] pbb_gates,
    output logic [6:0] pba_div_gates,
    output logic irq
);

    // divider mask: period minus one of the enable pulse
    function automatic logic [7:0] div_mask(input logic [7:0] cfg);
        div_mask = cfg[`BIT_DIV] ? (8'hff >> (3'd7 - cfg[2:0])) : 8'h00;
    endfunction

    // registers that need the unlock sequence
    function automatic logic is_locked(input logic [11:0] a);
        case (a)
            `OFF_MAIN_SRC, `OFF_CPU_DIV, `OFF_PBA_DIV, `OFF_PBB_DIV,
            `OFF_CPU_GATES, `OFF_HSB_GATES, `OFF_PBA_GATES,
            `OFF_PBB_GATES, `OFF_PBA_DIVGATES, `OFF_CFD_CTRL,
            `OFF_PERIPH_PWR, `OFF_ASYNC_WAKE: is_locked = 1'b1;
            default: is_locked = 1'b0;
        endcase
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        case (a)
            `OFF_MAIN_SRC, `OFF_CPU_DIV, `OFF_HSB_MIRROR, `OFF_PBA_DIV,
            `OFF_PBB_DIV, `OFF_CPU_GATES, `OFF_HSB_GATES, `OFF_PBA_GATES,
            `OFF_PBB_GATES, `OFF_PBA_DIVGATES, `OFF_CFD_CTRL, `OFF_UNLOCK,
            `OFF_IRQ_EN_SET, `OFF_IRQ_EN_CLR, `OFF_IRQ_EN_STATE,
            `OFF_IRQ_PEND, `OFF_IRQ_PEND_CLR, `OFF_STATUS,
            `OFF_PERIPH_PWR, `OFF_RST_SRC, `OFF_WAKE_SRC,
            `OFF_ASYNC_WAKE, `OFF_CONFIG, `OFF_REVISION: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    logic [2:0] main_src_ff;
    logic [7:0] cpu_cfg_ff, pba_cfg_ff, pbb_cfg_ff;
    logic [7:0] cpu_act_ff, pba_act_ff, pbb_act_ff;
    logic [31:0] cpu_gates_ff, hsb_gates_ff, pba_gates_ff, pbb_gates_ff;
    logic [6:0] pba_divg_ff;
    logic cfd_en_ff, sfv_ff;
    logic [31:0] ppwr_ff, awake_ff;
    logic unlocked_ff;
    logic [11:0] unlock_addr_ff;
    logic [31:0] imr_ff, isr_ff, sr_ff, sr_prev_ff;
    logic st_cfd_ff, st_clock_ready_flag_ff, st_ae_ff;
    logic [31:0] prdata_ff;
    logic pready_ff, pslverr_ff, irq_ff;
    logic [2:0] ext_sync_ff, main_sync_ff, rc_sync_ff;
    logic sys_reset_n_ff;
    logic seen_edge_ff, armed_ff;
    logic [7:0] div_cnt_ff;
    logic cpu_en_ff, pba_en_ff, pbb_en_ff;
    clkmgr_pkg::switch_state_t sw_state_ff, nxt_sw_state;

    // bus access decode, write lands at the completing edge
    logic acc, wr, setup;
    logic [11:0] a;
    logic wr_ok, wr_bad, cfd_fire, mon_active, main_rise, rc_rise;
    logic div_wr;
    assign a = paddr;
    assign setup = psel & ~penable;
    assign acc = psel & penable & pready_ff;
    assign wr = acc & pwrite;
    // locked write passes only right after a matching unlock
    assign wr_ok = wr & (~is_locked(a) | (unlocked_ff & unlock_addr_ff == a));
    assign wr_bad = wr & is_locked(a) & ~wr_ok;
    assign div_wr = wr_ok & (a == `OFF_CPU_DIV | a == `OFF_PBA_DIV |
                             a == `OFF_PBB_DIV);

    // APB answer: pready one cycle after setup, zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup & ~is_mapped(a);
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
        end else if (setup & ~pwrite) begin
            case (a)
                `OFF_MAIN_SRC: prdata_ff <= {29'h0, main_src_ff};
                `OFF_CPU_DIV: prdata_ff <= {24'h0, cpu_cfg_ff};
                `OFF_HSB_MIRROR: prdata_ff <= {24'h0, cpu_cfg_ff};
                `OFF_PBA_DIV: prdata_ff <= {24'h0, pba_cfg_ff};
                `OFF_PBB_DIV: prdata_ff <= {24'h0, pbb_cfg_ff};
                `OFF_CPU_GATES: prdata_ff <= cpu_gates_ff;
                `OFF_HSB_GATES: prdata_ff <= hsb_gates_ff;
                `OFF_PBA_GATES: prdata_ff <= pba_gates_ff;
                `OFF_PBB_GATES: prdata_ff <= pbb_gates_ff;
                `OFF_PBA_DIVGATES: prdata_ff <= {25'h0, pba_divg_ff};
                `OFF_CFD_CTRL: prdata_ff <= {sfv_ff, 30'h0, cfd_en_ff};
                `OFF_IRQ_EN_STATE: prdata_ff <= imr_ff;
                `OFF_IRQ_PEND: prdata_ff <= isr_ff;
                `OFF_STATUS: prdata_ff <= sr_ff;
                `OFF_PERIPH_PWR: prdata_ff <= ppwr_ff;
                `OFF_ASYNC_WAKE: prdata_ff <= awake_ff;
                `OFF_CONFIG: prdata_ff <= `VAL_CONFIG;
                `OFF_REVISION: prdata_ff <= `VAL_REVISION;
                default: prdata_ff <= 32'h00000000;
            endcase
        end
    end

    // unlock: key in top byte, target offset in low bits; one shot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlocked_ff <= 1'b0;
            unlock_addr_ff <= 12'h000;
        end else if (wr & a == `OFF_UNLOCK) begin
            unlocked_ff <= pwdata[31:`KEY_LSB] == `UNLOCK_KEY;
            unlock_addr_ff <= pwdata[11:0];
        end else if (wr) begin
            unlocked_ff <= 1'b0;
        end
    end

    // pin synchronisers, only stage two and three are looked at
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_sync_ff <= 3'h7;
            main_sync_ff <= 3'h0;
            rc_sync_ff <= 3'h0;
        end else begin
            ext_sync_ff <= {ext_sync_ff[1:0], ext_reset_n};
            main_sync_ff <= {main_sync_ff[1:0], main_clk_sample};
            rc_sync_ff <= {rc_sync_ff[1:0], rc_ref_sample};
        end
    end

    // external reset pin drives system reset request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_reset_n_ff <= 1'b0;
        end else begin
            sys_reset_n_ff <= ext_sync_ff[1];
        end
    end

    // failure detector: one reference period without a main edge
    assign main_rise = main_sync_ff[1] & ~main_sync_ff[2];
    assign rc_rise = rc_sync_ff[1] & ~rc_sync_ff[2];
    assign mon_active = cfd_en_ff & (main_src_ff != `SRC_SYSTEM_RC_OSC) &
                        main_clk_avail & ~deep_sleep;
    assign cfd_fire = mon_active & armed_ff & rc_rise &
                      ~seen_edge_ff & ~main_rise;

    // arming happens at the first reference rise after activation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_ff <= 1'b0;
            seen_edge_ff <= 1'b0;
        end else if (!mon_active) begin
            armed_ff <= 1'b0;
            seen_edge_ff <= 1'b0;
        end else if (rc_rise) begin
            armed_ff <= 1'b1;
            seen_edge_ff <= 1'b0;
        end else if (main_rise) begin
            seen_edge_ff <= 1'b1;
        end
    end

    // main source: failure overrides a software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_src_ff <= `SRC_SYSTEM_RC_OSC;
        end else if (cfd_fire) begin
            main_src_ff <= `SRC_SYSTEM_RC_OSC;
        end else if (wr_ok & a == `OFF_MAIN_SRC) begin
            main_src_ff <= pwdata[2:0];
        end
    end

    // detector control; final-value bit freezes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfd_en_ff <= 1'b0;
            sfv_ff <= 1'b0;
        end else if (wr_ok & a == `OFF_CFD_CTRL & ~sfv_ff) begin
            cfd_en_ff <= pwdata[`BIT_FAILURE_DETECT_ENABLE];
            sfv_ff <= pwdata[`BIT_SFV];
        end
    end

    // divider settings as written by software, bits 6:3 read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_cfg_ff <= 8'h00;
            pba_cfg_ff <= 8'h00;
            pbb_cfg_ff <= 8'h00;
        end else if (wr_ok) begin
            if (a == `OFF_CPU_DIV) cpu_cfg_ff <= pwdata[7:0] & 8'h87;
            if (a == `OFF_PBA_DIV) pba_cfg_ff <= pwdata[7:0] & 8'h87;
            if (a == `OFF_PBB_DIV) pbb_cfg_ff <= pwdata[7:0] & 8'h87;
        end
    end

    // gate masks and plain storage registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_gates_ff <= `RST_CPU_GATES;
            hsb_gates_ff <= `RST_HSB_GATES;
            pba_gates_ff <= `RST_PBA_GATES;
            pbb_gates_ff <= `RST_PBB_GATES;
            pba_divg_ff <= 7'h7f;
            ppwr_ff <= `RST_PERIPH_PWR;
            awake_ff <= 32'h00000000;
        end else if (wr_ok) begin
            case (a)
                `OFF_CPU_GATES: cpu_gates_ff <= pwdata;
                `OFF_HSB_GATES: hsb_gates_ff <= pwdata;
                `OFF_PBA_GATES: pba_gates_ff <= pwdata;
                `OFF_PBB_GATES: pbb_gates_ff <= pwdata;
                `OFF_PBA_DIVGATES: pba_divg_ff <= pwdata[6:0];
                `OFF_PERIPH_PWR: ppwr_ff <= pwdata;
                `OFF_ASYNC_WAKE: awake_ff <= pwdata;
                default: ;
            endcase
        end
    end

    // switch sequencer: wait for a common period boundary
    always_comb begin
        nxt_sw_state = sw_state_ff;
        case (sw_state_ff)
            clkmgr_pkg::SW_IDLE: begin
                if (div_wr) nxt_sw_state = clkmgr_pkg::SW_WAIT;
            end
            clkmgr_pkg::SW_WAIT: begin
                // a write on the wrap edge is not applied yet: keep waiting
                if (div_cnt_ff == 8'hff && !div_wr)
                    nxt_sw_state = clkmgr_pkg::SW_SETTLE;
            end
            clkmgr_pkg::SW_SETTLE: begin
                nxt_sw_state = div_wr ? clkmgr_pkg::SW_WAIT
                                      : clkmgr_pkg::SW_IDLE;
            end
            default: nxt_sw_state = clkmgr_pkg::SW_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_state_ff <= clkmgr_pkg::SW_IDLE;
        end else begin
            sw_state_ff <= nxt_sw_state;
        end
    end

    // active settings change only at the all-divider wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_act_ff <= 8'h00;
            pba_act_ff <= 8'h00;
            pbb_act_ff <= 8'h00;
        end else if (sw_state_ff == clkmgr_pkg::SW_WAIT &&
                     div_cnt_ff == 8'hff) begin
            cpu_act_ff <= cpu_cfg_ff;
            pba_act_ff <= pba_cfg_ff;
            pbb_act_ff <= pbb_cfg_ff;
        end
    end

    // free counter; wrap is a boundary of every divided clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_ff <= 8'h00;
        end else begin
            div_cnt_ff <= div_cnt_ff + 8'h01;
        end
    end

    // divided clock enables, hsb follows the processor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_en_ff <= 1'b0;
            pba_en_ff <= 1'b0;
            pbb_en_ff <= 1'b0;
        end else begin
            cpu_en_ff <= (div_cnt_ff & div_mask(cpu_act_ff)) ==
                         div_mask(cpu_act_ff);
            pba_en_ff <= (div_cnt_ff & div_mask(pba_act_ff)) ==
                         div_mask(pba_act_ff);
            pbb_en_ff <= (div_cnt_ff & div_mask(pbb_act_ff)) ==
                         div_mask(pbb_act_ff);
        end
    end

    // status flags; hardware set beats clear, but a divider write beats the clock-ready set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_clock_ready_flag_ff <= 1'b1;
            st_cfd_ff <= 1'b0;
            st_ae_ff <= 1'b0;
        end else begin
            if (div_wr) st_clock_ready_flag_ff <= 1'b0;
            else if (sw_state_ff == clkmgr_pkg::SW_SETTLE)
                st_clock_ready_flag_ff <= 1'b1;
            if (cfd_fire) st_cfd_ff <= 1'b1;
            else if (wr_ok & a == `OFF_MAIN_SRC) st_cfd_ff <= 1'b0;
            if (wr_bad) st_ae_ff <= 1'b1;
            else if (wr_ok & is_locked(a)) st_ae_ff <= 1'b0;
        end
    end

    always_comb begin
        sr_ff = 32'h00000000;
        sr_ff[`BIT_ST_CFD] = st_cfd_ff;
        sr_ff[`BIT_ST_CLOCK_READY_FLAG] = st_clock_ready_flag_ff;
        sr_ff[`BIT_ST_AE] = st_ae_ff;
    end

    // pending bits latch status rises; a rise beats a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr_prev_ff <= 32'h00000020;
            isr_ff <= 32'h00000000;
        end else begin
            sr_prev_ff <= sr_ff;
            isr_ff <= (sr_ff & ~sr_prev_ff) |
                      (isr_ff & ~((wr & a == `OFF_IRQ_PEND_CLR) ?
                                  pwdata : 32'h00000000));
        end
    end

    // enable state; only ones written have effect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imr_ff <= 32'h00000000;
        end else if (wr & a == `OFF_IRQ_EN_SET) begin
            imr_ff <= imr_ff | (pwdata & 32'h00000061);
        end else if (wr & a == `OFF_IRQ_EN_CLR) begin
            imr_ff <= imr_ff & ~pwdata;
        end
    end

    // single request from all enabled pending sources
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(isr_ff & imr_ff);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign sys_reset_n = sys_reset_n_ff;
    assign main_src_sel = main_src_ff;
    assign cpu_clk_en = cpu_en_ff;
    assign hsb_clk_en = cpu_en_ff;
    assign pba_clk_en = pba_en_ff;
    assign pbb_clk_en = pbb_en_ff;
    assign cpu_gates = cpu_gates_ff;
    assign hsb_gates = hsb_gates_ff;
    assign pba_gates = pba_gates_ff;
    assign pbb_gates = pbb_gates_ff;
    assign pba_div_gates = pba_divg_ff;
    assign irq = irq_ff;

    // checks
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_EXT_RESET: assert property (
        !ext_sync_ff[1] |=> !sys_reset_n_ff)
        else $error("external reset did not reach system reset");
    AST_FAIL_SWITCH: assert property (
        cfd_fire |=> main_src_ff == `SRC_SYSTEM_RC_OSC && st_cfd_ff)
        else $error("failure did not switch source");
    AST_FAIL_PEND: assert property (
        cfd_fire && !st_cfd_ff |-> ##2 isr_ff[`BIT_ST_CFD])
        else $error("failure not pending");
    AST_NO_MON_RC: assert property (
        main_src_ff == `SRC_SYSTEM_RC_OSC || deep_sleep || !main_clk_avail
        |-> !cfd_fire)
        else $error("detector fired while idle");
    AST_ACC_ERR: assert property (
        wr_bad |=> st_ae_ff)
        else $error("locked write without unlock not flagged");
    AST_CLOCK_READY_FLAG_CLR: assert property (
        div_wr |=> !st_clock_ready_flag_ff)
        else $error("clock ready not cleared by divider write");
    AST_CLOCK_READY_FLAG_SET: assert property (
        sw_state_ff == clkmgr_pkg::SW_SETTLE && !div_wr
        |=> st_clock_ready_flag_ff ##1 isr_ff[`BIT_ST_CLOCK_READY_FLAG])
        else $error("clock ready rise not pending");
    AST_MIRROR: assert property (
        setup && !pwrite && a == `OFF_HSB_MIRROR
        |=> prdata == {24'h0, $past(cpu_cfg_ff)})
        else $error("mirror read differs");
    AST_PEND_HOLD: assert property (
        isr_ff[`BIT_ST_AE] && !(wr && a == `OFF_IRQ_PEND_CLR)
        |=> isr_ff[`BIT_ST_AE])
        else $error("pending bit lost without clear");
    AST_IRQ_OR: assert property (
        |(isr_ff & imr_ff) |=> irq)
        else $error("request missing");
    AST_UNDIV: assert property (
        !cpu_act_ff[`BIT_DIV] && !pba_act_ff[`BIT_DIV]
        |=> cpu_clk_en && pba_clk_en)
        else $error("undivided clock not every cycle");

    COV_FAIL: cover property (cfd_fire ##1 main_src_ff == `SRC_SYSTEM_RC_OSC);
    COV_SWITCH: cover property (div_wr ##[1:300] st_clock_ready_flag_ff);
    COV_ACC_ERR: cover property (wr_bad ##1 st_ae_ff);

endmodule // clock_manager

`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "clkmgr_params.svh"

module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, sys_reset_n, irq;
    logic cpu_clk_en, hsb_clk_en, pba_clk_en, pbb_clk_en;
    logic [2:0] main_src_sel;
    logic [31:0] cpu_gates, hsb_gates, pba_gates, pbb_gates;
    logic [6:0] pba_div_gates;
    logic ext_reset_n = 1'b1;
    logic main_clk_sample = 1'b0;
    logic rc_ref_sample = 1'b0;
    logic main_clk_avail = 1'b1;
    logic deep_sleep = 1'b0;
    logic main_run = 1'b1;
    logic [3:0] rc_cnt = 4'h0;
    logic last_err;
    logic [31:0] rd;
    int fail_count = 0;
    int check_count = 0;
    int n, c, h, p, b;
    logic [11:0] ra [17] = '{`OFF_MAIN_SRC, `OFF_CPU_DIV, `OFF_HSB_MIRROR,
        `OFF_PBA_DIV, `OFF_PBB_DIV, `OFF_CPU_GATES, `OFF_HSB_GATES,
        `OFF_PBA_GATES, `OFF_PBB_GATES, `OFF_PBA_DIVGATES, `OFF_CFD_CTRL,
        `OFF_IRQ_EN_STATE, `OFF_IRQ_PEND, `OFF_STATUS, `OFF_PERIPH_PWR,
        `OFF_ASYNC_WAKE, `OFF_CONFIG};
    logic [31:0] rv [17] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        `RST_CPU_GATES, `RST_HSB_GATES, `RST_PBA_GATES, `RST_PBB_GATES,
        `RST_PBA_DIVGATES, 32'h0, 32'h0, 32'h0, 32'h00000020,
        `RST_PERIPH_PWR, 32'h0, `VAL_CONFIG};

    clock_manager dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_reset_n(ext_reset_n), .main_clk_sample(main_clk_sample),
        .rc_ref_sample(rc_ref_sample), .main_clk_avail(main_clk_avail),
        .deep_sleep(deep_sleep), .sys_reset_n(sys_reset_n),
        .main_src_sel(main_src_sel), .cpu_clk_en(cpu_clk_en),
        .hsb_clk_en(hsb_clk_en), .pba_clk_en(pba_clk_en),
        .pbb_clk_en(pbb_clk_en), .cpu_gates(cpu_gates),
        .hsb_gates(hsb_gates), .pba_gates(pba_gates), .pbb_gates(pbb_gates),
        .pba_div_gates(pba_div_gates), .irq(irq));

    always #5 pclk = ~pclk;

    // main clock toggles each cycle, reference far slower so edges fit
    always @(posedge pclk) begin
        if (main_run)
            main_clk_sample <= ~main_clk_sample;
        rc_cnt <= rc_cnt + 4'h1;
        if (rc_cnt == 4'hf)
            rc_ref_sample <= ~rc_ref_sample;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic timed_out();
        fail_count++;
        $display("timeout at %0t", $time);
        wrap_up();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one transfer, then one idle edge so no signal is driven twice
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50)
            timed_out();
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // locked writes need the key write just before them
    task automatic locked_wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, `OFF_UNLOCK, {`UNLOCK_KEY, 12'h000, a});
        apb(1'b1, a, d);
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
    endtask

    task automatic wait_ready();
        for (n = 0; n < 400; n++) begin
            apb(1'b0, `OFF_STATUS, 32'h0);
            if (rd[`BIT_ST_CLOCK_READY_FLAG] === 1'b1)
                break;
        end
        if (n == 400)
            timed_out();
    endtask

    task automatic count_en();
        c = 0;
        h = 0;
        p = 0;
        b = 0;
        repeat (64) begin
            @(posedge pclk);
            c += int'(cpu_clk_en);
            h += int'(hsb_clk_en);
            p += int'(pba_clk_en);
            b += int'(pbb_clk_en);
        end
    endtask

    initial begin
        tick(8);
        presetn <= 1'b1;
        tick(2);
        for (int i = 0; i < 17; i++)
            rd_chk(ra[i], rv[i]);
        chk(cpu_gates, `RST_CPU_GATES);
        chk(hsb_gates, `RST_HSB_GATES);
        chk(pba_gates, `RST_PBA_GATES);
        chk(pbb_gates, `RST_PBB_GATES);
        chk({25'h0, pba_div_gates}, `RST_PBA_DIVGATES);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        chk({31'h0, last_err}, 32'h1);
        $display("test reset_and_map done");

        apb(1'b1, `OFF_CPU_DIV, 32'h00000083);
        rd_chk(`OFF_CPU_DIV, 32'h0);
        rd_chk(`OFF_STATUS, 32'h00000060);
        locked_wr(`OFF_CPU_DIV, 32'h00000083);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(rd & 32'h20, 32'h0);
        wait_ready();
        rd_chk(`OFF_HSB_MIRROR, 32'h00000083);
        // the mirror is read-only: a write must leave it alone
        apb(1'b1, `OFF_HSB_MIRROR, 32'h00000000);
        rd_chk(`OFF_HSB_MIRROR, 32'h00000083);
        count_en();
        chk(c, 4);
        chk(h, 4);
        chk(b, 64);
        rd_chk(`OFF_IRQ_PEND, 32'h00000060);
        locked_wr(`OFF_PBA_DIV, 32'h00000080);
        wait_ready();
        count_en();
        chk(p, 32);
        // back to undivided, select written as zero with the bit
        locked_wr(`OFF_PBA_DIV, 32'h00000000);
        wait_ready();
        count_en();
        chk(p, 64);
        $display("test dividers done");

        apb(1'b1, `OFF_IRQ_EN_SET, 32'h00000020);
        tick(3);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `OFF_IRQ_EN_SET, 32'h0);
        rd_chk(`OFF_IRQ_EN_STATE, 32'h00000020);
        apb(1'b1, `OFF_IRQ_PEND_CLR, 32'h00000020);
        rd_chk(`OFF_IRQ_PEND, 32'h00000040);
        tick(3);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `OFF_IRQ_EN_SET, 32'h00000040);
        tick(3);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `OFF_IRQ_EN_CLR, 32'h00000060);
        rd_chk(`OFF_IRQ_EN_STATE, 32'h0);
        apb(1'b1, `OFF_IRQ_PEND_CLR, 32'h00000040);
        tick(3);
        chk({31'h0, irq}, 32'h0);
        $display("test interrupts done");

        // divide by sixteen is already set, so the fast rc code is safe
        for (int i = 0; i < 4; i++) begin
            locked_wr(`OFF_MAIN_SRC, 32'(i));
            tick(2);
            chk({29'h0, main_src_sel}, 32'(i));
        end
        locked_wr(`OFF_MAIN_SRC, 32'h1);
        locked_wr(`OFF_CFD_CTRL, 32'h1);
        tick(100);
        chk({29'h0, main_src_sel}, 32'h1);
        deep_sleep <= 1'b1;
        main_run <= 1'b0;
        tick(150);
        chk({29'h0, main_src_sel}, 32'h1);
        deep_sleep <= 1'b0;
        main_clk_avail <= 1'b0;
        tick(150);
        chk({29'h0, main_src_sel}, 32'h1);
        main_clk_avail <= 1'b1;
        for (n = 0; n < 300 && main_src_sel !== 3'h0; n++)
            @(posedge pclk);
        if (n == 300)
            timed_out();
        rd_chk(`OFF_MAIN_SRC, 32'h0);
        tick(4);
        rd_chk(`OFF_IRQ_PEND, 32'h00000001);
        apb(1'b1, `OFF_IRQ_EN_SET, 32'h00000001);
        tick(3);
        chk({31'h0, irq}, 32'h1);
        $display("test failure_detect done");

        ext_reset_n <= 1'b0;
        tick(6);
        chk({31'h0, sys_reset_n}, 32'h0);
        ext_reset_n <= 1'b1;
        tick(6);
        chk({31'h0, sys_reset_n}, 32'h1);
        $display("test ext_reset done");
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire
